// ### shared/iwdt_defs.svh
// iwdt_defs.svh: constants of the initial watchdog timeout block.
// assumes a 100 MHz reference clock; included by bare name.
`ifndef IWDT_DEFS_SVH
`define IWDT_DEFS_SVH

// -------------------------------------------------------------------
// clock
// -------------------------------------------------------------------
`define IWDT_CLK_PERIOD_NS    64'd10

// -------------------------------------------------------------------
// timing, in their own units
// -------------------------------------------------------------------
`define IWDT_UPPER_TIMEOUT_MS 64'd1600
`define IWDT_RESET_TIMEOUT_MS 64'd200

// both times round down to whole cycles
`define IWDT_UPPER_TIMEOUT_CYC \
  ((`IWDT_UPPER_TIMEOUT_MS * 64'd1000000) / `IWDT_CLK_PERIOD_NS)
`define IWDT_RESET_TIMEOUT_CYC \
  ((`IWDT_RESET_TIMEOUT_MS * 64'd1000000) / `IWDT_CLK_PERIOD_NS)

// -------------------------------------------------------------------
// initial period multipliers, in upper periods
// -------------------------------------------------------------------
`define IWDT_MULT_W           7
`define IWDT_MULT_GND         7'h01
`define IWDT_MULT_OPEN        7'h08
`define IWDT_MULT_VCC         7'h40

// -------------------------------------------------------------------
// reset values
// -------------------------------------------------------------------
`define IWDT_SYNC_RST         4'h0
`define IWDT_SEL_RST          2'h0

`endif

// ### shared/iwdt_pkg.sv
// iwdt_pkg: types of the initial watchdog timeout block.
// assumes nothing of its surroundings.
package iwdt_pkg;

  // -----------------------------------------------------------------
  // select strap, as decoded from the three-level pin
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    IWDT_SEL_GND  = 2'h0,
    IWDT_SEL_OPEN = 2'h1,
    IWDT_SEL_VCC  = 2'h2,
    IWDT_SEL_BAD  = 2'h3
  } iwdt_sel_t;

  // -----------------------------------------------------------------
  // watchdog states
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    IWDT_ST_HOLD,
    IWDT_ST_INIT,
    IWDT_ST_NORMAL
  } iwdt_state_t;

endpackage : iwdt_pkg

// ### rtl/iwdt_sync2.sv
// iwdt_sync2: two flip-flop synchroniser for asynchronous pins.
// assumes each bit is an independent level or a slow static strap.
`timescale 1ns/1ps
module iwdt_sync2 #(
  parameter int unsigned        WIDTH   = 1,
  parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : iwdt_sync2

// ### rtl/iwdt_top.sv
// iwdt_top: supervisor watchdog with a selectable first timeout.
// assumes pins arrive asynchronously and REF_CLK runs at 100 MHz.
//
// Overview of operation
// - select low: first period equals upper timeout
// - select open: first period is eight upper timeouts
// - select high: first period is sixty-four upper timeouts
// - reset output rising clears counter, starts first period
// - no kick in first period raises fault
// - after first kick, every period is upper timeout
// - timeout latches fault low and pulls reset low
// - kicks ignored while reset output is low
// - kick after reset release sets fault flag high
`timescale 1ns/1ps
`include "iwdt_defs.svh"
module iwdt_top
  import iwdt_pkg::*;
#(
  parameter int unsigned UPPER_TIMEOUT_CYCLES = 32'(`IWDT_UPPER_TIMEOUT_CYC),
  parameter int unsigned RESET_TIMEOUT_CYCLES = 32'(`IWDT_RESET_TIMEOUT_CYC)
) (
  // clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RESETN,
  // supply monitor request, low while a supply or manual reset is active
  input  wire logic       SUPPLY_RESET_REQ_N,
  // processor side
  input  wire logic       WATCHDOG_KICK_INPUT,
  input  wire logic [1:0] INITIAL_TIMEOUT_SELECT,
  // outputs
  output logic            RESET_OUT_N,
  output logic            WATCHDOG_FAULT_FLAG_N
);

  // -----------------------------------------------------------------
  // reset release
  // -----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_sync;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_q <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_sync <= rst_meta_q;
    end
  end

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [3:0] pins_s;
  logic       kick_s;
  logic       req_n_s;
  iwdt_sel_t  sel_s;

  iwdt_sync2 #(
    .WIDTH   (4),
    .RST_VAL (`IWDT_SYNC_RST)
  ) u_sync (
    .clk   (REF_CLK),
    .rst_n (rst_n_sync),
    .d     ({SUPPLY_RESET_REQ_N, WATCHDOG_KICK_INPUT, INITIAL_TIMEOUT_SELECT}),
    .q     (pins_s)
  );

  assign req_n_s = pins_s[3];
  assign kick_s  = pins_s[2];
  assign sel_s   = iwdt_sel_t'(pins_s[1:0]);

  // -----------------------------------------------------------------
  // events
  // -----------------------------------------------------------------
  localparam logic [31:0] UPPER_LAST = 32'(UPPER_TIMEOUT_CYCLES - 1);
  localparam logic [31:0] RESET_LAST = 32'(RESET_TIMEOUT_CYCLES - 1);

  iwdt_state_t            state_q;
  logic                   kick_prev_q;
  logic [31:0]            period_cnt_q;
  logic [31:0]            hold_cnt_q;
  logic [`IWDT_MULT_W-1:0] mult_cnt_q;
  logic [`IWDT_MULT_W-1:0] mult_q;
  logic                   req;
  logic                   kick_edge;
  logic                   period_end;
  logic                   init_last;
  logic                   hold_done;
  logic                   timeout;
  logic                   running;

  assign req        = !req_n_s;
  assign running    = (state_q != IWDT_ST_HOLD) && !req;
  assign kick_edge  = (kick_s ^ kick_prev_q) && running;
  assign period_end = (period_cnt_q == UPPER_LAST);
  assign init_last  = period_end && (mult_cnt_q == mult_q - 7'h01);
  assign hold_done  = (hold_cnt_q == RESET_LAST);
  // a kick in the expiry cycle still counts: kick beats timeout
  assign timeout    = running && !kick_edge &&
                      (((state_q == IWDT_ST_INIT) && init_last) ||
                       ((state_q == IWDT_ST_NORMAL) && period_end));

  // -----------------------------------------------------------------
  // kick history
  // -----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      kick_prev_q <= 1'b0;
    end else begin
      kick_prev_q <= kick_s;
    end
  end

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_q <= IWDT_ST_HOLD;
    end else if (req) begin
      state_q <= IWDT_ST_HOLD;
    end else begin
      unique case (state_q)
        IWDT_ST_HOLD: begin
          if (hold_done) begin
            state_q <= IWDT_ST_INIT;
          end
        end
        IWDT_ST_INIT: begin
          if (kick_edge) begin
            state_q <= IWDT_ST_NORMAL;
          end else if (timeout) begin
            state_q <= IWDT_ST_HOLD;
          end
        end
        IWDT_ST_NORMAL: begin
          if (timeout) begin
            state_q <= IWDT_ST_HOLD;
          end
        end
        default: begin
          state_q <= IWDT_ST_HOLD;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // reset hold timer, restarts while a request is active
  // -----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      hold_cnt_q <= '0;
    end else if ((state_q != IWDT_ST_HOLD) || req || hold_done) begin
      hold_cnt_q <= '0;
    end else begin
      hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
    end
  end

  // -----------------------------------------------------------------
  // period counter and multiple counter
  // -----------------------------------------------------------------
  // the first period is counted in whole upper periods: a single
  // 64x counter would need 34 bits at the default rate
  always_ff @(posedge REF_CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      period_cnt_q <= '0;
    end else if (!running || kick_edge || period_end) begin
      period_cnt_q <= '0;
    end else begin
      period_cnt_q <= period_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      mult_cnt_q <= '0;
    end else if (!running || kick_edge) begin
      mult_cnt_q <= '0;
    end else if ((state_q == IWDT_ST_INIT) && period_end) begin
      mult_cnt_q <= mult_cnt_q + 7'h01;
    end
  end

  // -----------------------------------------------------------------
  // select strap, tracked in hold so it is frozen at the rising edge
  // -----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      mult_q <= `IWDT_MULT_GND;
    end else if (state_q == IWDT_ST_HOLD) begin
      unique case (sel_s)
        IWDT_SEL_GND:  mult_q <= `IWDT_MULT_GND;
        IWDT_SEL_VCC:  mult_q <= `IWDT_MULT_VCC;
        // undecodable level taken as open, the safer long choice
        default:       mult_q <= `IWDT_MULT_OPEN;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      RESET_OUT_N <= 1'b0;
    end else if (req || timeout) begin
      RESET_OUT_N <= 1'b0;
    end else if ((state_q == IWDT_ST_HOLD) && hold_done) begin
      RESET_OUT_N <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      WATCHDOG_FAULT_FLAG_N <= 1'b1;
    end else if (timeout) begin
      WATCHDOG_FAULT_FLAG_N <= 1'b0;
    end else if (kick_edge) begin
      WATCHDOG_FAULT_FLAG_N <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n_sync);

  sequence s_release;
    !RESET_OUT_N ##1 RESET_OUT_N;
  endsequence

  sequence s_fault_entry;
    !RESET_OUT_N && !WATCHDOG_FAULT_FLAG_N && (state_q == IWDT_ST_HOLD);
  endsequence

  property p_mult_gnd;
    (state_q == IWDT_ST_HOLD) && (sel_s == IWDT_SEL_GND) |=> mult_q == 7'h01;
  endproperty
  a_mult_gnd: assert property (p_mult_gnd) else $error("gnd select not x1");

  property p_mult_open;
    (state_q == IWDT_ST_HOLD) && (sel_s == IWDT_SEL_OPEN) |=> mult_q == 7'h08;
  endproperty
  a_mult_open: assert property (p_mult_open) else $error("open select not x8");

  property p_mult_vcc;
    (state_q == IWDT_ST_HOLD) && (sel_s == IWDT_SEL_VCC) |=> mult_q == 7'h40;
  endproperty
  a_mult_vcc: assert property (p_mult_vcc) else $error("vcc select not x64");

  property p_rise_clears;
    s_release |-> (period_cnt_q == 32'h0000_0000) && (mult_cnt_q == 7'h00)
                  && (state_q == IWDT_ST_INIT);
  endproperty
  a_rise_clears: assert property (p_rise_clears) else $error("rise did not restart");

  property p_init_expiry;
    (state_q == IWDT_ST_INIT) && init_last && !kick_edge && !req |=> s_fault_entry;
  endproperty
  a_init_expiry: assert property (p_init_expiry) else $error("no fault at init expiry");

  property p_normal_after_kick;
    (state_q == IWDT_ST_INIT) && kick_edge && !req |=>
      (state_q == IWDT_ST_NORMAL) && (period_cnt_q == 32'h0000_0000);
  endproperty
  a_normal_after_kick: assert property (p_normal_after_kick) else $error("no normal mode");

  property p_timeout_both;
    $fell(RESET_OUT_N) && $past(req_n_s) |-> $past(timeout) && !WATCHDOG_FAULT_FLAG_N;
  endproperty
  a_timeout_both: assert property (p_timeout_both) else $error("reset without fault");

  property p_ignore_in_reset;
    !RESET_OUT_N && !$past(timeout) |-> $stable(WATCHDOG_FAULT_FLAG_N);
  endproperty
  a_ignore_in_reset: assert property (p_ignore_in_reset) else $error("flag moved in reset");

  property p_kick_clears_flag;
    RESET_OUT_N && running && (kick_s != kick_prev_q) |=> WATCHDOG_FAULT_FLAG_N;
  endproperty
  a_kick_clears_flag: assert property (p_kick_clears_flag) else $error("flag not cleared");

  property p_any_edge;
    running && (kick_s != kick_prev_q) |=> (period_cnt_q == 32'h0000_0000)
                                        && (mult_cnt_q == 7'h00);
  endproperty
  a_any_edge: assert property (p_any_edge) else $error("edge did not restart");

endmodule : iwdt_top

// ### bench/iwdt_proc_model.sv
// iwdt_proc_model: supervised processor that toggles the watchdog kick pin.
// assumes the bench sets en and gap just after a rising clock edge.
`timescale 1ns/1ps
module iwdt_proc_model (
  // clock
  input  wire logic        clk,
  // control from the bench
  input  wire logic        en,
  input  wire logic [31:0] gap,
  // kick pin, push-pull
  output logic             kick
);
  int cnt;

  initial begin
    kick = 1'b0;
    cnt  = 0;
  end

  // -----------------------------------------------------------------
  // single kick, each call flips the level
  // -----------------------------------------------------------------
  task toggle();
    kick = ~kick;
  endtask : toggle

  // -----------------------------------------------------------------
  // periodic kicks, gap cycles apart; a slow gap starves the watchdog
  // -----------------------------------------------------------------
  always @(posedge clk) begin
    if (en) begin
      cnt = cnt + 1;
      if (cnt >= int'(gap)) begin
        cnt = 0;
        #1 kick = ~kick;
      end
    end else begin
      cnt = 0;
    end
  end
endmodule : iwdt_proc_model

// ### bench/iwdt_top_tb.sv
// iwdt_top_tb: self-checking bench for the initial watchdog timeout block.
// assumes short timeouts through parameters; cycle counts follow the hand-over walk.
`timescale 1ns/1ps
module iwdt_top_tb;
  import iwdt_pkg::*;

  localparam int unsigned N = 20;
  localparam int unsigned R = 10;

  logic       ref_clk;
  logic       resetn;
  logic       supply_req_n;
  logic       kick;
  logic [1:0] sel;
  logic       reset_out_n;
  logic       flag_n;
  logic       model_en;
  int         model_gap;
  int         n_errors;
  int         n_tests;
  int         seed;
  int         n;
  logic [1:0] sels [4] = '{2'h0, 2'h1, 2'h2, 2'h3};

  // -----------------------------------------------------------------
  // design and processor
  // -----------------------------------------------------------------
  iwdt_top #(
    .UPPER_TIMEOUT_CYCLES (N),
    .RESET_TIMEOUT_CYCLES (R)
  ) dut_u (
    .REF_CLK                (ref_clk),
    .RESETN                 (resetn),
    .SUPPLY_RESET_REQ_N     (supply_req_n),
    .WATCHDOG_KICK_INPUT    (kick),
    .INITIAL_TIMEOUT_SELECT (sel),
    .RESET_OUT_N            (reset_out_n),
    .WATCHDOG_FAULT_FLAG_N  (flag_n)
  );

  iwdt_proc_model proc_u (
    .clk  (ref_clk),
    .en   (model_en),
    .gap  (model_gap),
    .kick (kick)
  );

  always #5 ref_clk = ~ref_clk;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic int mult(input logic [1:0] s);
    case (s)
      2'h0:    return 1;
      2'h2:    return 64;
      default: return 8; // code 3 reads as open
    endcase
  endfunction : mult

  task automatic test_done();
    $display("errors %0d, checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick

  // bounded wait for a reset output level
  task automatic wait_out(input logic val, input int bound);
    int i;
    i = 0;
    while (reset_out_n !== val && i < bound) begin
      i++;
      tick();
    end
    if (reset_out_n !== val) begin
      n_errors++;
      $display("unexpected at %0t: wait for reset output ran out", $time);
      test_done();
    end
  endtask : wait_out

  // count samples while the reset output keeps a level
  task automatic measure(input logic val, output int cnt);
    cnt = 0;
    while (reset_out_n === val && cnt < 5000) begin
      cnt++;
      tick();
    end
    if (cnt >= 5000) begin
      n_errors++;
      $display("unexpected at %0t: reset output level outlasted the bound", $time);
    end
  endtask : measure

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    seed         = 32'h45e2_c5a1;
    ref_clk      = 1'b0;
    resetn       = 1'b0;
    supply_req_n = 1'b1;
    sel          = sels[0];
    model_en     = 1'b0;
    model_gap    = 5;
    n_errors     = 0;
    n_tests      = 0;
    repeat (16) @(posedge ref_clk);
    #1 resetn = 1'b1;
    wait_out(1'b1, 100);
    // each select code, no kicks: first period, fault, hold with kicks ignored
    for (int i = 0; i < 4; i++) begin
      measure(1'b1, n);
      chk(n, mult(sels[i]) * N, "first period");
      chk({31'h0, flag_n}, 32'h0, "flag at timeout");
      sel = (i < 3) ? sels[i + 1] : 2'h2;
      proc_u.toggle();
      measure(1'b0, n);
      chk(n, R, "hold length with kick during hold");
      chk({31'h0, flag_n}, 32'h0, "flag after hold");
    end
    // one kick early in a long first period, then normal period applies
    repeat (5) tick();
    proc_u.toggle();
    tick();
    tick();
    chk({31'h0, flag_n}, 32'h0, "flag before kick lands");
    tick();
    chk({31'h0, flag_n}, 32'h1, "flag cleared by kick");
    measure(1'b1, n);
    chk(n, N, "period after first kick");
    wait_out(1'b1, 50);
    // random kick spacing inside the period keeps reset high
    repeat (6) begin
      model_gap = 1 + ($unsigned($random(seed)) % (N - 4));
      model_en  = 1'b1;
      repeat (4 * N) begin
        tick();
        chk({31'h0, reset_out_n}, 32'h1, "reset while kicked");
      end
    end
    chk({31'h0, flag_n}, 32'h1, "flag while kicked");
    // supply request: its release restarts the long first period
    model_en     = 1'b0;
    supply_req_n = 1'b0;
    wait_out(1'b0, 6);
    repeat (3) tick();
    supply_req_n = 1'b1;
    wait_out(1'b1, 100);
    measure(1'b1, n);
    chk(n, 64 * N, "first period after supply reset");
    chk({31'h0, flag_n}, 32'h0, "flag after supply path timeout");
    test_done();
  end
endmodule : iwdt_top_tb
